// *** src/temp_sensor_command_registers.sv ***
// Purpose: Serial command decoder, register set and conversion timing of the sensor.
// Assumes: adc_code comes from logic on ref_clk; link pins are asynchronous.
// Notes:   Alarm pins are open drain; oe high pulls the line low.
module temp_sensor_command_registers
   import temp_sensor_pkg::*;
#(
   parameter int unsigned CONV_CYCLES_P = temp_sensor_pkg::CONV_CYCLES
) (
   // Clock, reset and enable
   input  wire logic        ref_clk,
   input  wire logic        srst,
   input  wire logic        clk_en,
   // Serial link from the host
   input  wire logic        cs_n,
   input  wire logic        sclk,
   input  wire logic        sio_in,
   output logic             sio_out,
   output logic             sio_oe,
   // Converter result
   input  wire logic [12:0] adc_code,
   // Open drain alarm line
   input  wire logic        alarm_line_in,
   output logic             alarm_line_out,
   output logic             alarm_line_oe,
   // Open drain critical line
   input  wire logic        critical_temp_in,
   output logic             critical_temp_out,
   output logic             critical_temp_oe
);
   import temp_sensor_pkg::*;

   // ****************************************
   // Declarations
   // ****************************************
   localparam logic [CONV_CNT_W-1:0] CONV_LAST = CONV_CNT_W'(CONV_CYCLES_P - 1);

   logic                  cs_n_s, sclk_s, sio_s;
   logic                  cs_n_d, sclk_d;
   logic                  sclk_rise, sclk_fall, cs_fall, cs_rise;
   link_state_t           state;
   logic [CNT_W-1:0]      bit_count;
   logic [7:0]            cmd_shift, cmd_reg, next_cmd;
   logic [REG_W-1:0]      wdata, dout, rd_value;
   logic                  cmd_done, frame_ok, commit_wr, temp_read_done;
   logic [REG_W-1:0]      temp_reg, cfg_reg, hyst_reg, crit_reg, low_reg, high_reg;
   logic [CONV_CNT_W-1:0] conv_cnt;
   logic                  shutdown, conv_restart, conv_done;
   deg_t                  t_now, d_hyst, d_crit, d_low, d_high;
   logic                  crit_flag, high_flag, low_flag;
   logic                  alert_fault, crit_fault;

   // ****************************************
   // Command decoding
   // ****************************************
   // Read codes all carry the start and read bits.
   function automatic logic is_read_cmd(input logic [7:0] c);
      return (c == CMD_RD_TEMP) || (c == CMD_RD_CFG) || (c == CMD_RD_HYST) ||
             (c == CMD_RD_CRIT) || (c == CMD_RD_LOW) || (c == CMD_RD_HIGH);
   endfunction

   // There is deliberately no write code for the temperature word.
   function automatic logic is_write_cmd(input logic [7:0] c);
      return (c == CMD_WR_CFG) || (c == CMD_WR_HYST) || (c == CMD_WR_CRIT) ||
             (c == CMD_WR_LOW) || (c == CMD_WR_HIGH);
   endfunction

   // Limit word as a 1/16 degree value; the low seven bits are dropped.
   function automatic deg_t deg_of(input logic [REG_W-1:0] lim);
      return {{2{lim[REG_W-1]}}, lim[REG_W-1:LIMIT_LSB], 4'h0};
   endfunction

   // ****************************************
   // Pin sampling
   // ****************************************
   pin_sync #(
      .WIDTH     (3),
      .RESET_VAL (3'h4)
   ) u_pin_sync (
      .ref_clk  (ref_clk),
      .srst     (srst),
      .clk_en   (clk_en),
      .async_in ({cs_n, sclk, sio_in}),
      .sync_out ({cs_n_s, sclk_s, sio_s})
   );

   // Delayed copies give the edges of the sampled serial clock and select.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cs_n_d <= 1'b1;
         sclk_d <= 1'b0;
      end else if (clk_en) begin
         cs_n_d <= cs_n_s;
         sclk_d <= sclk_s;
      end
   end

   assign sclk_rise = clk_en && !cs_n_s && sclk_s && !sclk_d;
   assign sclk_fall = clk_en && !cs_n_s && !sclk_s && sclk_d;
   assign cs_fall   = clk_en && cs_n_d && !cs_n_s;
   assign cs_rise   = clk_en && !cs_n_d && cs_n_s;

   // ****************************************
   // Link state machine
   // ****************************************
   assign next_cmd = {cmd_shift[6:0], sio_s};
   assign cmd_done = sclk_rise && (state == L_CMD) && (bit_count == CNT_W'(CMD_BITS - 1));

   // Bits arrive MSB first on rising edges; a 25th edge spoils the frame.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state     <= L_IDLE;
         bit_count <= '0;
         cmd_shift <= 8'h00;
         wdata     <= 16'h0000;
      end else if (clk_en) begin
         if (cs_n_s) begin
            state     <= L_IDLE;
            bit_count <= '0;
         end else if (sclk_rise) begin
            case (state)
               L_IDLE, L_CMD: begin
                  cmd_shift <= next_cmd;
                  bit_count <= bit_count + CNT_W'(1);
                  state     <= (bit_count == CNT_W'(CMD_BITS - 1)) ? L_DATA : L_CMD;
               end
               L_DATA: begin
                  if (bit_count == CNT_W'(FRAME_BITS)) begin
                     state <= L_OVER;
                  end else begin
                     wdata     <= {wdata[14:0], sio_s};
                     bit_count <= bit_count + CNT_W'(1);
                  end
               end
               L_OVER: state <= L_OVER;
               default: state <= L_IDLE;
            endcase
         end
      end
   end

   // A frame counts only when select rises right after the 24th clock.
   assign frame_ok       = cs_rise && (state == L_DATA) && (bit_count == CNT_W'(FRAME_BITS));
   assign commit_wr      = frame_ok && is_write_cmd(cmd_reg);
   assign temp_read_done = frame_ok && (cmd_reg == CMD_RD_TEMP);

   // ****************************************
   // Read path
   // ****************************************
   // Register chosen by the command just completed.
   always_comb begin
      rd_value = 16'h0000;
      if (next_cmd == CMD_RD_TEMP) begin
         rd_value = temp_reg;
      end else if (next_cmd == CMD_RD_CFG) begin
         rd_value = cfg_reg;
      end else if (next_cmd == CMD_RD_HYST) begin
         rd_value = hyst_reg;
      end else if (next_cmd == CMD_RD_CRIT) begin
         rd_value = crit_reg;
      end else if (next_cmd == CMD_RD_LOW) begin
         rd_value = low_reg;
      end else if (next_cmd == CMD_RD_HIGH) begin
         rd_value = high_reg;
      end
   end

   // The word is captured at the 8th rising edge so a later conversion
   // cannot tear it; the line is driven from the 8th falling edge on.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cmd_reg <= 8'h00;
         dout    <= 16'h0000;
         sio_out <= 1'b0;
         sio_oe  <= 1'b0;
      end else if (clk_en) begin
         if (cs_n_s) begin
            cmd_reg <= 8'h00;
            sio_oe  <= 1'b0;
         end else if (cmd_done) begin
            cmd_reg <= next_cmd;
            dout    <= rd_value;
         end else if (sclk_fall && (state == L_DATA) && is_read_cmd(cmd_reg) &&
                      (bit_count < CNT_W'(FRAME_BITS))) begin
            sio_oe  <= 1'b1;
            sio_out <= dout[15];
            dout    <= {dout[14:0], 1'b0};
         end
      end
   end

   // ****************************************
   // Register writes
   // ****************************************
   // Configuration keeps only its five live bits.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cfg_reg <= CFG_RESET;
      end else if (commit_wr && (cmd_reg == CMD_WR_CFG)) begin
         cfg_reg <= wdata & CFG_MASK;
      end
   end

   // The four limits are stored whole; comparisons drop the low bits.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         hyst_reg <= HYST_RESET;
         crit_reg <= CRIT_RESET;
         low_reg  <= LOW_RESET;
         high_reg <= HIGH_RESET;
      end else if (commit_wr) begin
         if (cmd_reg == CMD_WR_HYST) begin
            hyst_reg <= wdata;
         end else if (cmd_reg == CMD_WR_CRIT) begin
            crit_reg <= wdata;
         end else if (cmd_reg == CMD_WR_LOW) begin
            low_reg <= wdata;
         end else if (cmd_reg == CMD_WR_HIGH) begin
            high_reg <= wdata;
         end
      end
   end

   // ****************************************
   // Conversion engine
   // ****************************************
   assign shutdown     = cfg_reg[CFG_SHUTDOWN_BIT];
   assign conv_restart = cs_fall || (cmd_done && (next_cmd == CMD_RD_TEMP));
   assign conv_done    = clk_en && !shutdown && !conv_restart && (conv_cnt == CONV_LAST);

   // Free-running timebase; shutdown freezes it and a falling select edge restarts it.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         conv_cnt <= '0;
      end else if (clk_en) begin
         if (conv_restart) begin
            conv_cnt <= '0;
         end else if (!shutdown) begin
            conv_cnt <= (conv_cnt == CONV_LAST) ? '0 : conv_cnt + CONV_CNT_W'(1);
         end
      end
   end

   // Comparisons in 1/16 degree; hysteresis differences cannot overflow.
   assign t_now     = {{2{adc_code[12]}}, adc_code};
   assign d_hyst    = deg_of(hyst_reg);
   assign d_crit    = deg_of(crit_reg);
   assign d_low     = deg_of(low_reg);
   assign d_high    = deg_of(high_reg);
   assign crit_flag = t_now > d_crit;
   assign high_flag = t_now > d_high;
   assign low_flag  = t_now < d_low;

   // Only a finished conversion updates the word; reads see the last one.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         temp_reg <= TEMP_RESET;
      end else if (conv_done) begin
         temp_reg <= {adc_code, crit_flag, high_flag, low_flag};
      end
   end

   // ****************************************
   // Alarm outputs
   // ****************************************
   fault_filter u_alert_filter (
      .ref_clk       (ref_clk),
      .srst          (srst),
      .clk_en        (clk_en),
      .sample_strobe (conv_done),
      .enter_cond    (high_flag || low_flag),
      .leave_cond    ((t_now < d_high - d_hyst) && (t_now > d_low + d_hyst)),
      .queue_en      (cfg_reg[CFG_QUEUE_BIT]),
      .latch_mode    (cfg_reg[CFG_INTR_BIT]),
      .read_clear    (temp_read_done),
      .fault_out     (alert_fault)
   );

   fault_filter u_crit_filter (
      .ref_clk       (ref_clk),
      .srst          (srst),
      .clk_en        (clk_en),
      .sample_strobe (conv_done),
      .enter_cond    (crit_flag),
      .leave_cond    (t_now < d_crit - d_hyst),
      .queue_en      (cfg_reg[CFG_QUEUE_BIT]),
      .latch_mode    (1'b0),
      .read_clear    (1'b0),
      .fault_out     (crit_fault)
   );

   // Open drain: the line is pulled low when the polarity says so.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         alarm_line_oe    <= 1'b0;
         critical_temp_oe <= 1'b0;
      end else if (clk_en) begin
         alarm_line_oe    <= alert_fault ^ cfg_reg[CFG_ALERT_POL_BIT];
         critical_temp_oe <= crit_fault ^ cfg_reg[CFG_CRIT_POL_BIT];
      end
   end

   // The drivers never push high; the wire readbacks are not needed.
   assign alarm_line_out    = 1'b0;
   assign critical_temp_out = 1'b0;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   sequence s_cs_fall;
      cs_fall;
   endsequence

   sequence s_temp_cmd;
      cmd_done && (next_cmd == CMD_RD_TEMP);
   endsequence

   a_start_marker: assert property (
      $rose(sio_oe) |-> cmd_reg[7] && cmd_reg[6])
      else $error("serial line driven without a read command");
   a_write_valid: assert property (
      $changed(hyst_reg) |-> $past(commit_wr) && ($past(cmd_reg) == CMD_WR_HYST))
      else $error("hysteresis changed without its write command");
   a_temp_load: assert property (
      s_temp_cmd |=> (dout == $past(temp_reg)) && (conv_cnt == '0))
      else $error("temperature read did not load the word or restart");
   a_cfg_write: assert property (
      commit_wr && (cmd_reg == CMD_WR_CFG) |=> cfg_reg == ($past(wdata) & CFG_MASK))
      else $error("configuration write lost");
   a_cfg_reserved: assert property (
      (cfg_reg & ~CFG_MASK) == 16'h0000)
      else $error("reserved configuration bit set");
   a_frame_exact: assert property (
      $changed(low_reg) |-> $past(cs_rise) && ($past(bit_count) == CNT_W'(FRAME_BITS)))
      else $error("low limit written outside a 24 clock frame");
   a_shutdown_hold: assert property (
      shutdown |=> $stable(temp_reg))
      else $error("temperature changed in shutdown");
   a_conv_restart: assert property (
      s_cs_fall |=> conv_cnt == '0)
      else $error("access did not restart conversion");
   a_conv_wrap: assert property (
      conv_done |=> (conv_cnt == '0) && (temp_reg[15:TEMP_LSB] == $past(adc_code)))
      else $error("conversion did not complete and restart");
   a_limit_reset: assert property (
      $past(srst) |-> (low_reg == LOW_RESET) && (high_reg == HIGH_RESET))
      else $error("limit reset value wrong");
   a_temp_ro: assert property (
      $changed(temp_reg) |-> $past(conv_done))
      else $error("temperature changed without a conversion");
endmodule

// *** shared/temp_sensor_pkg.sv ***
// Purpose: Shared constants and types of the temperature sensor register block.
// Assumes: One 250 MHz reference clock for all logic.
// Notes:   Temperatures are compared in units of 1/16 degree.
package temp_sensor_pkg;

   // ****************************************
   // Frame and register widths
   // ****************************************
   localparam int REG_W      = 16;
   localparam int CMD_BITS   = 8;
   localparam int FRAME_BITS = 24;
   localparam int CNT_W      = 5;
   localparam int CONV_CNT_W = 27;
   localparam int QUEUE_DEPTH = 4;

   // ****************************************
   // Command codes
   // ****************************************
   localparam logic [7:0] CMD_RD_TEMP = 8'hC1;
   localparam logic [7:0] CMD_RD_CFG  = 8'hC3;
   localparam logic [7:0] CMD_RD_HYST = 8'hC5;
   localparam logic [7:0] CMD_RD_CRIT = 8'hC7;
   localparam logic [7:0] CMD_RD_LOW  = 8'hC9;
   localparam logic [7:0] CMD_RD_HIGH = 8'hCB;
   localparam logic [7:0] CMD_WR_CFG  = 8'h83;
   localparam logic [7:0] CMD_WR_HYST = 8'h85;
   localparam logic [7:0] CMD_WR_CRIT = 8'h87;
   localparam logic [7:0] CMD_WR_LOW  = 8'h89;
   localparam logic [7:0] CMD_WR_HIGH = 8'h8B;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int CFG_SHUTDOWN_BIT  = 8;
   localparam int CFG_INTR_BIT      = 9;
   localparam int CFG_CRIT_POL_BIT  = 10;
   localparam int CFG_ALERT_POL_BIT = 11;
   localparam int CFG_QUEUE_BIT     = 12;
   localparam logic [15:0] CFG_MASK = 16'h1F00;
   localparam int TEMP_LSB = 3;
   localparam int LIMIT_LSB = 7;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [15:0] TEMP_RESET = 16'h0000;
   localparam logic [15:0] CFG_RESET  = 16'h0000;
   localparam logic [15:0] HYST_RESET = 16'h0000;
   localparam logic [15:0] CRIT_RESET = 16'h0000;
   localparam logic [15:0] LOW_RESET  = 16'h0500;
   localparam logic [15:0] HIGH_RESET = 16'h2000;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CONV_PERIOD_MS = 500;
   localparam int CLK_MHZ        = 250;
   localparam int CONV_CYCLES    = CONV_PERIOD_MS * 1000 * CLK_MHZ;

   typedef logic signed [14:0] deg_t;
   typedef enum logic [3:0] {
      L_IDLE = 4'h1,
      L_CMD  = 4'h2,
      L_DATA = 4'h4,
      L_OVER = 4'h8
   } link_state_t;

endpackage

// *** src/pin_sync.sv ***
// Purpose: Two-stage synchroniser for pins from outside the clock domain.
// Assumes: Inputs change slowly against ref_clk.
// Notes:   The first stage feeds only the second stage.
module pin_sync #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // Clock and control
   input  wire logic             ref_clk,
   input  wire logic             srst,
   input  wire logic             clk_en,
   // Pins in and synchronised copies out
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   // One pair of flops per pin; reset value keeps idle lines idle.
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge ref_clk) begin
         if (srst) begin
            stage1[i]   <= RESET_VAL[i];
            sync_out[i] <= RESET_VAL[i];
         end else if (clk_en) begin
            stage1[i]   <= async_in[i];
            sync_out[i] <= stage1[i];
         end
      end
   end
endmodule

// *** src/fault_filter.sv ***
// Purpose: Hysteresis trip state with optional fault queue and latch.
// Assumes: sample_strobe is one cycle per finished conversion.
// Notes:   In latch mode every trip change sets the latch until read.
module fault_filter (
   // Clock and control
   input  wire logic ref_clk,
   input  wire logic srst,
   input  wire logic clk_en,
   // Conversion results
   input  wire logic sample_strobe,
   input  wire logic enter_cond,
   input  wire logic leave_cond,
   // Mode
   input  wire logic queue_en,
   input  wire logic latch_mode,
   input  wire logic read_clear,
   // Result
   output logic      fault_out
);
   import temp_sensor_pkg::*;
   logic       tripped;
   logic       latched;
   logic [2:0] run;
   logic       want;
   logic       flip;
   logic [2:0] need;

   assign want = tripped ? leave_cond : enter_cond;
   assign need = queue_en ? 3'(QUEUE_DEPTH) : 3'h1;
   assign flip = sample_strobe && want && (run + 3'h1 >= need);

   // Count consecutive conversions agreeing with a change of state.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         run     <= 3'h0;
         tripped <= 1'b0;
      end else if (clk_en && sample_strobe) begin
         if (!want) begin
            run <= 3'h0;
         end else if (flip) begin
            run     <= 3'h0;
            tripped <= !tripped;
         end else begin
            run <= run + 3'h1;
         end
      end
   end

   // A new trip change wins over a clearing read in the same cycle.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         latched <= 1'b0;
      end else if (clk_en) begin
         if (flip) begin
            latched <= 1'b1;
         end else if (read_clear) begin
            latched <= 1'b0;
         end
      end
   end

   assign fault_out = latch_mode ? latched : tripped;
endmodule

// *** testbench/serial_host_model.sv ***
// Purpose: Host controller model for the three-wire sensor link.
// Assumes: Link clock period of 125 ns, idle low between frames.
// Notes:   A released data line shows a toggling pattern.
module serial_host_model (
   // Link pins
   output logic      cs_n,
   output logic      sclk,
   output logic      sio_in,
   input  wire logic sio_out,
   input  wire logic sio_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   logic hbit;
   logic hen;
   // Line level; it toggles when nobody drives, so a stale bit never passes.
   assign sio_in = sio_oe ? sio_out : (hen ? hbit : ~hbit);
   // Idle pins.
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      hbit = 1'b0;
      hen  = 1'b1;
   end
   // One frame of n clocks, command then data, MSB first.
   task automatic frame(input logic [7:0] cmd, input logic [15:0] wd,
                        input int n, output logic [15:0] rd);
      logic [23:0] sh;
      sh = {cmd, wd};
      cs_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         if (hen) hbit = sh[23];
         else hbit = ~hbit;
         sh = sh << 1;
         #62.5 sclk = 1'b1;
         rd = {rd[14:0], sio_in};
         #62.5 sclk = 1'b0;
         if (i == 7 && cmd[6]) hen = 1'b0;
      end
      #62.5 cs_n = 1'b1;
      hen = 1'b1;
      #50;
   endtask
endmodule

// *** testbench/test_temp_sensor_command_registers.sv ***
// Purpose: Self-checking bench of the sensor command and register block.
// Assumes: Short conversion period of 64 clocks.
// Notes:   The converter code is held steady during each frame.
module test_temp_sensor_command_registers;
   timeunit 1ns;
   timeprecision 100ps;
   import temp_sensor_pkg::*;
   localparam logic [7:0] WCMD [5] = '{CMD_WR_CFG, CMD_WR_HYST, CMD_WR_CRIT,
                                       CMD_WR_LOW, CMD_WR_HIGH};
   logic        ref_clk, srst, clk_en, cs_n, sclk, sio_in, sio_out, sio_oe;
   logic        al_oe, cr_oe, al_out, cr_out;
   logic [12:0] adc_code;
   logic [15:0] rd, lfsr;
   logic [15:0] lim [3];
   int          n_errors, total_checks;

   temp_sensor_command_registers #(.CONV_CYCLES_P(64)) u_dut (
      .ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .cs_n(cs_n), .sclk(sclk),
      .sio_in(sio_in), .sio_out(sio_out), .sio_oe(sio_oe), .adc_code(adc_code),
      .alarm_line_in(1'b1), .alarm_line_out(al_out), .alarm_line_oe(al_oe),
      .critical_temp_in(1'b1), .critical_temp_out(cr_out), .critical_temp_oe(cr_oe));
   serial_host_model u_host (.cs_n(cs_n), .sclk(sclk), .sio_in(sio_in),
      .sio_out(sio_out), .sio_oe(sio_oe));

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [15:0] nxt(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   // Limits keep whole degrees in the top nine bits; codes are in 1/16 degree.
   function automatic logic [15:0] exp_temp(input logic [12:0] a,
                                            input logic [15:0] cr, hi, lo);
      int t;
      t = $signed(a);
      return {a, t > $signed(cr[15:7]) * 16, t > $signed(hi[15:7]) * 16,
              t < $signed(lo[15:7]) * 16};
   endfunction
   task automatic check(input logic [15:0] got, exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] cmd, input logic [15:0] exp);
      u_host.frame(cmd, 16'h0000, 24, rd);
      check(rd, exp, "read");
      check({15'h0000, sio_oe}, 16'h0000, "line released");
   endtask
   task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
      u_host.frame(cmd, d, 24, rd);
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // Clock and watchdog; a hang counts as a mismatch.
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   initial begin
      #400000;
      n_errors++;
      stop_test;
   end

   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      srst = 1'b1;
      clk_en = 1'b1;
      adc_code = 13'h0000;
      lfsr = 16'hA568;
      repeat (4) @(negedge ref_clk);
      srst = 1'b0;
      repeat (4) @(negedge ref_clk);
      rd_chk(CMD_RD_CFG, 16'h0000);
      rd_chk(CMD_RD_LOW, 16'h0500);
      rd_chk(CMD_RD_HIGH, 16'h2000);
      rd_chk(CMD_RD_TEMP, 16'h0001);
      // Random words through every writable register; unused config bits drop.
      for (int i = 0; i < 5; i++) begin
         lfsr = nxt(lfsr);
         wr(WCMD[i], lfsr);
         rd_chk(WCMD[i] | 8'h40, i == 0 ? lfsr & 16'h1F00 : lfsr);
      end
      wr(CMD_WR_CFG, 16'h0000);
      // Random temperatures against random limits.
      for (int i = 0; i < 4; i++) begin
         @(negedge ref_clk);
         adc_code = lfsr[12:0];
         lim[0] = nxt(lfsr);
         lim[1] = nxt(lim[0]);
         lim[2] = nxt(lim[1]);
         lfsr = lim[2];
         for (int k = 0; k < 3; k++) wr(WCMD[k + 2], lim[k]);
         rd_chk(CMD_RD_TEMP, exp_temp(adc_code, lim[0], lim[2], lim[1]));
      end
      // Temperature equal to the critical, low and high limits; low seven limit bits are ignored.
      @(negedge ref_clk);
      adc_code = 13'h00A0;
      for (int k = 0; k < 3; k++) wr(WCMD[k + 2], 16'h057F);
      rd_chk(CMD_RD_TEMP, 16'h0500);
      // Short, long, unknown and unmarked frames change nothing.
      wr(CMD_WR_HYST, 16'h0100);
      u_host.frame(CMD_WR_HYST, 16'h0F0F, 23, rd);
      u_host.frame(CMD_WR_HYST, 16'h0F0F, 25, rd);
      wr(8'h8D, 16'h0F0F);
      wr(8'h05, 16'h0F0F);
      rd_chk(CMD_RD_HYST, 16'h0100);
      // Shutdown keeps the last result.
      wr(CMD_WR_CFG, 16'h0100);
      wr(8'h81, 16'h0F0F);
      @(negedge ref_clk);
      adc_code = 13'h0640;
      repeat (200) @(negedge ref_clk);
      rd_chk(CMD_RD_TEMP, 16'h0500);
      rd_chk(CMD_RD_CFG, 16'h0100);
      // Comparator pins at 100 degrees, then polarity flipped, then cooled.
      wr(CMD_WR_CFG, 16'h0000);
      wr(CMD_WR_CRIT, 16'h2000);
      wr(CMD_WR_HIGH, 16'h2000);
      wr(CMD_WR_LOW, 16'h0500);
      repeat (200) @(negedge ref_clk);
      check({12'h000, al_out, cr_out, al_oe, cr_oe}, 16'h0003, "pins hot");
      wr(CMD_WR_CFG, 16'h0C00);
      repeat (10) @(negedge ref_clk);
      check({14'h0000, al_oe, cr_oe}, 16'h0000, "pins inverted");
      @(negedge ref_clk);
      adc_code = 13'h0000;
      repeat (200) @(negedge ref_clk);
      check({14'h0000, al_oe, cr_oe}, 16'h0001, "pins cold");
      // Interrupt mode: a temperature read clears the alarm, a return re-arms it.
      wr(CMD_WR_CFG, 16'h0200);
      rd_chk(CMD_RD_TEMP, exp_temp(adc_code, 16'h2000, 16'h2000, 16'h0500));
      check({14'h0000, al_oe, cr_oe}, 16'h0000, "alarm cleared");
      @(negedge ref_clk);
      adc_code = 13'h0190;
      repeat (200) @(negedge ref_clk);
      check({14'h0000, al_oe, cr_oe}, 16'h0002, "alarm re-armed");
      rd_chk(CMD_RD_TEMP, exp_temp(adc_code, 16'h2000, 16'h2000, 16'h0500));
      check({14'h0000, al_oe, cr_oe}, 16'h0000, "alarm read");
      // Fault queue: four low conversions in a row before the alarm trips.
      wr(CMD_WR_CFG, 16'h1000);
      @(negedge ref_clk);
      adc_code = 13'h0000;
      repeat (128) @(negedge ref_clk);
      check({14'h0000, al_oe, cr_oe}, 16'h0000, "queue waiting");
      repeat (200) @(negedge ref_clk);
      check({14'h0000, al_oe, cr_oe}, 16'h0002, "queue tripped");
      // A reset in mid-run clears the configuration and releases the pins.
      srst = 1'b1;
      repeat (4) @(negedge ref_clk);
      srst = 1'b0;
      repeat (4) @(negedge ref_clk);
      check({14'h0000, al_oe, cr_oe}, 16'h0000, "pins after reset");
      rd_chk(CMD_RD_CFG, CFG_RESET);
      stop_test;
   end
endmodule
